// File: emt_map.svh
// register map, field positions and timing constants of the external memory timing block
`ifndef EMT_MAP_SVH
`define EMT_MAP_SVH

`define EMT_IDX_TIMING      10'h0AA
`define EMT_IDX_CONFIG      10'h0A0
`define EMT_IDX_PAGE        10'h0A1
`define EMT_IDX_STATUS      10'h0A2

`define EMT_TIMING_RESET    8'hFF
`define EMT_CONFIG_RESET    8'h00
`define EMT_PAGE_RESET      8'h00

`define EMT_TC_SETUP_HI     7
`define EMT_TC_SETUP_LO     6
`define EMT_TC_STROBE_HI    5
`define EMT_TC_STROBE_LO    2
`define EMT_TC_HOLD_HI      1
`define EMT_TC_HOLD_LO      0

`define EMT_CF_MUX_BIT      4
`define EMT_CF_MODE_HI      3
`define EMT_CF_MODE_LO      2
`define EMT_CF_LATCH_HI     1
`define EMT_CF_LATCH_LO     0

`define EMT_TAIL_CYCLES     5'h02
`define EMT_INT_RAM_BYTES   8192

`endif

// File: emt_pkg.sv
// types shared by the external memory timing block
package emt_pkg;

	typedef enum logic [1:0] {
		EMT_MODE_INTERNAL = 2'b00,
		EMT_MODE_SPLIT    = 2'b01,
		EMT_MODE_BANKED   = 2'b10,
		EMT_MODE_EXTERNAL = 2'b11
	} emt_mode_e;

	typedef enum logic [3:0] {
		EMT_ST_IDLE   = 4'h0,
		EMT_ST_INT    = 4'h1,
		EMT_ST_ADDR   = 4'h2,
		EMT_ST_ALE_HI = 4'h3,
		EMT_ST_ALE_LO = 4'h4,
		EMT_ST_SETUP  = 4'h5,
		EMT_ST_STROBE = 4'h6,
		EMT_ST_HOLD   = 4'h7,
		EMT_ST_TAIL   = 4'h8,
		EMT_ST_DONE   = 4'h9
	} emt_state_e;

endpackage

// File: emt_ram.sv
// on-chip data RAM with registered read data
`timescale 1ns/100ps
module emt_ram #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	input  wire logic          we,
	input  wire logic          re,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (re) begin
			rdata <= mem[addr];
		end
	end

endmodule

// File: emt_ext_mem.sv
// external data memory mode decode and programmable strobe timing with APB registers
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`include "emt_map.svh"
module emt_ext_mem
	import emt_pkg::*;
#(
	parameter int RAM_BYTES = `EMT_INT_RAM_BYTES,
	parameter int RAM_AW    = 13
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// external move requests from the core
	input  wire logic        req,
	input  wire logic        req_write,
	input  wire logic        req_wide,
	input  wire logic [15:0] data_pointer,
	input  wire logic [7:0]  indirect_low,
	input  wire logic [7:0]  req_wdata,
	output logic             req_busy,
	output logic             req_done,
	output logic [7:0]       req_rdata,
	// external memory pins
	output logic [7:0]       addr_hi_out,
	output logic             addr_hi_oe,
	output logic [7:0]       addr_lo_out,
	output logic             addr_lo_oe,
	output logic [7:0]       data_out,
	output logic             data_oe,
	input  wire logic [7:0]  data_in,
	output logic             ale,
	output logic             rd_n,
	output logic             wr_n
);

	function automatic logic [4:0] cnt_load(input logic [4:0] cycles);
		cnt_load = cycles - 5'h01;
	endfunction

	// registers
	logic [7:0]  ext_mem_timing_reg;
	logic [7:0]  ext_mem_config_reg;
	logic [7:0]  ext_mem_page_reg;
	logic        pready_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;

	// access state
	emt_state_e  state_reg;
	emt_state_e  state_next;
	logic [4:0]  cnt_reg;
	logic [4:0]  cnt_next;
	logic [15:0] ea_reg;
	logic        wr_reg;
	logic        wide_reg;
	logic        hi_drive_reg;
	logic        mux_reg;
	logic        last_off_reg;
	logic [7:0]  wdata_reg;
	logic [4:0]  setup_cyc_reg;
	logic [4:0]  strobe_cyc_reg;
	logic [4:0]  hold_cyc_reg;
	logic [4:0]  latch_cyc_reg;

	// pin and answer flops
	logic [7:0]  addr_hi_reg;
	logic        addr_hi_oe_reg;
	logic [7:0]  addr_lo_reg;
	logic        addr_lo_oe_reg;
	logic [7:0]  data_out_reg;
	logic        data_oe_reg;
	logic        ale_reg;
	logic        rd_n_reg;
	logic        wr_n_reg;
	logic        done_reg;
	logic        busy_reg;
	logic [7:0]  rdata_reg;

	// APB decode
	wire logic [9:0] reg_idx     = paddr[11:2];
	wire logic       hit_timing  = (reg_idx == `EMT_IDX_TIMING);
	wire logic       hit_config  = (reg_idx == `EMT_IDX_CONFIG);
	wire logic       hit_page    = (reg_idx == `EMT_IDX_PAGE);
	wire logic       hit_status  = (reg_idx == `EMT_IDX_STATUS);
	wire logic       hit_any     = hit_timing | hit_config | hit_page | hit_status;
	wire logic       apb_access  = psel & penable;
	wire logic       apb_commit  = apb_access & pready_reg;
	wire logic       apb_wr      = apb_commit & pwrite & hit_any;
	wire logic [7:0] status_word = {last_off_reg, busy_reg, 2'b00, state_reg};
	wire logic [7:0] rd_byte     = hit_timing ? ext_mem_timing_reg :
	                               hit_config ? ext_mem_config_reg :
	                               hit_page   ? ext_mem_page_reg   :
	                               hit_status ? status_word : 8'h00;

	// timing and config fields
	wire emt_mode_e  mode        = emt_mode_e'(ext_mem_config_reg[`EMT_CF_MODE_HI:`EMT_CF_MODE_LO]);
	wire logic       mux_sel     = ~ext_mem_config_reg[`EMT_CF_MUX_BIT];
	wire logic [1:0] latch_sel   = ext_mem_config_reg[`EMT_CF_LATCH_HI:`EMT_CF_LATCH_LO];
	wire logic [1:0] setup_sel   = ext_mem_timing_reg[`EMT_TC_SETUP_HI:`EMT_TC_SETUP_LO];
	wire logic [3:0] strobe_sel  = ext_mem_timing_reg[`EMT_TC_STROBE_HI:`EMT_TC_STROBE_LO];
	wire logic [1:0] hold_sel    = ext_mem_timing_reg[`EMT_TC_HOLD_HI:`EMT_TC_HOLD_LO];
	wire logic [4:0] setup_cyc   = {3'b000, setup_sel};
	wire logic [4:0] strobe_cyc  = {1'b0, strobe_sel} + 5'h01;
	wire logic [4:0] hold_cyc    = {3'b000, hold_sel};
	wire logic [4:0] latch_cyc   = {3'b000, latch_sel} + 5'h01;

	// effective address and destination
	wire logic [15:0] ea_byte    = {ext_mem_page_reg, indirect_low};
	wire logic [15:0] ea         = req_wide ? data_pointer : ea_byte;
	wire logic        above_ram  = ({16'h0000, ea} >= 32'(RAM_BYTES));
	wire logic        go_off     = (mode == EMT_MODE_EXTERNAL) |
	                               (((mode == EMT_MODE_SPLIT) |
	                                 (mode == EMT_MODE_BANKED)) &
	                                above_ram);
	// a byte access outside banked mode leaves the high byte with the port latches so software can bank by hand
	wire logic        hi_drive   = req_wide | (mode == EMT_MODE_BANKED);
	wire logic        accept     = req & (state_reg == EMT_ST_IDLE);
	wire logic        int_start  = accept & ~go_off;
	wire logic        ext_start  = accept & go_off;
	wire logic        ram_we     = int_start & req_write;
	wire logic        ram_re     = int_start & ~req_write;
	wire logic        cnt_zero   = (cnt_reg == 5'h00);
	wire logic [7:0]  ram_q;

	emt_ram #(
		.AW (RAM_AW),
		.DW (8)
	) u_ram (
		.clock (clock),
		.rstn  (rstn),
		.we    (ram_we),
		.re    (ram_re),
		.addr  (ea[RAM_AW-1:0]),
		.wdata (req_wdata),
		.rdata (ram_q)
	);

	// APB register file
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ext_mem_timing_reg <= `EMT_TIMING_RESET;
			ext_mem_config_reg <= `EMT_CONFIG_RESET;
			ext_mem_page_reg   <= `EMT_PAGE_RESET;
		end else if (apb_wr) begin
			if (hit_timing) ext_mem_timing_reg <= pwdata[7:0];
			if (hit_config) ext_mem_config_reg <= {3'b000, pwdata[4:0]};
			if (hit_page)   ext_mem_page_reg   <= pwdata[7:0];
		end
	end

	// one wait state: the answer and read data come from flops
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= apb_access & ~pready_reg;
			pslverr_reg <= apb_access & ~pready_reg & ~hit_any;
			if (apb_access & ~pready_reg) prdata_reg <= {24'h000000, rd_byte};
		end
	end

	// sequencer: ADDR, TAIL(2) and DONE form the fixed four-cycle overhead
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_zero ? 5'h00 : cnt_reg - 5'h01;
		case (state_reg)
			EMT_ST_IDLE: begin
				if (int_start) state_next = EMT_ST_INT;
				if (ext_start) state_next = EMT_ST_ADDR;
			end
			EMT_ST_INT: begin
				state_next = EMT_ST_DONE;
			end
			EMT_ST_ADDR: begin
				if (mux_reg) begin
					state_next = EMT_ST_ALE_HI;
					cnt_next   = cnt_load(latch_cyc_reg);
				end else if (setup_cyc_reg != 5'h00) begin
					state_next = EMT_ST_SETUP;
					cnt_next   = cnt_load(setup_cyc_reg);
				end else begin
					state_next = EMT_ST_STROBE;
					cnt_next   = cnt_load(strobe_cyc_reg);
				end
			end
			EMT_ST_ALE_HI: begin
				if (cnt_zero) begin
					state_next = EMT_ST_ALE_LO;
					cnt_next   = cnt_load(latch_cyc_reg);
				end
			end
			EMT_ST_ALE_LO: begin
				if (cnt_zero && setup_cyc_reg != 5'h00) begin
					state_next = EMT_ST_SETUP;
					cnt_next   = cnt_load(setup_cyc_reg);
				end else if (cnt_zero) begin
					state_next = EMT_ST_STROBE;
					cnt_next   = cnt_load(strobe_cyc_reg);
				end
			end
			EMT_ST_SETUP: begin
				if (cnt_zero) begin
					state_next = EMT_ST_STROBE;
					cnt_next   = cnt_load(strobe_cyc_reg);
				end
			end
			EMT_ST_STROBE: begin
				if (cnt_zero && hold_cyc_reg != 5'h00) begin
					state_next = EMT_ST_HOLD;
					cnt_next   = cnt_load(hold_cyc_reg);
				end else if (cnt_zero) begin
					state_next = EMT_ST_TAIL;
					cnt_next   = cnt_load(`EMT_TAIL_CYCLES);
				end
			end
			EMT_ST_HOLD: begin
				if (cnt_zero) begin
					state_next = EMT_ST_TAIL;
					cnt_next   = cnt_load(`EMT_TAIL_CYCLES);
				end
			end
			EMT_ST_TAIL: begin
				if (cnt_zero) state_next = EMT_ST_DONE;
			end
			EMT_ST_DONE: begin
				state_next = EMT_ST_IDLE;
			end
			default: begin
				state_next = EMT_ST_IDLE;
				cnt_next   = 5'h00;
			end
		endcase
	end

	// timing is snapshot at accept so a register write cannot bend a running access
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg      <= EMT_ST_IDLE;
			cnt_reg        <= 5'h00;
			ea_reg         <= 16'h0000;
			wr_reg         <= 1'b0;
			wide_reg       <= 1'b0;
			hi_drive_reg   <= 1'b0;
			mux_reg        <= 1'b0;
			last_off_reg   <= 1'b0;
			wdata_reg      <= 8'h00;
			setup_cyc_reg  <= 5'h00;
			strobe_cyc_reg <= 5'h01;
			hold_cyc_reg   <= 5'h00;
			latch_cyc_reg  <= 5'h01;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (accept) begin
				ea_reg         <= ea;
				wr_reg         <= req_write;
				wide_reg       <= req_wide;
				hi_drive_reg   <= hi_drive;
				mux_reg        <= mux_sel;
				last_off_reg   <= go_off;
				wdata_reg      <= req_wdata;
				setup_cyc_reg  <= setup_cyc;
				strobe_cyc_reg <= strobe_cyc;
				hold_cyc_reg   <= hold_cyc;
				latch_cyc_reg  <= latch_cyc;
			end
		end
	end

	// pin decode from the next state so every pin comes from a flop
	wire logic last_off_next = accept ? go_off : last_off_reg;
	wire logic mux_next  = accept ? mux_sel : mux_reg;
	wire logic nx_ext    = (state_next != EMT_ST_IDLE) && (state_next != EMT_ST_INT) &&
	                       (state_next != EMT_ST_DONE) && last_off_next;
	wire logic nx_strobe = (state_next == EMT_ST_STROBE);
	wire logic nx_ale    = (state_next == EMT_ST_ALE_HI);
	wire logic nx_alen   = nx_ale | (state_next == EMT_ST_ADDR && mux_next);
	wire logic [15:0] ea_next = accept ? ea : ea_reg;
	wire logic wr_next   = accept ? req_write : wr_reg;
	wire logic hi_next   = accept ? hi_drive : hi_drive_reg;
	wire logic [7:0] wd_next = accept ? req_wdata : wdata_reg;
	wire logic data_phase = nx_ext & ~nx_alen & wr_next &
	                        (state_next != EMT_ST_ADDR) & (state_next != EMT_ST_ALE_LO);
	wire logic capture   = (state_reg == EMT_ST_STROBE) & cnt_zero & ~wr_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			addr_hi_reg    <= 8'h00;
			addr_hi_oe_reg <= 1'b0;
			addr_lo_reg    <= 8'h00;
			addr_lo_oe_reg <= 1'b0;
			data_out_reg   <= 8'h00;
			data_oe_reg    <= 1'b0;
			ale_reg        <= 1'b0;
			rd_n_reg       <= 1'b1;
			wr_n_reg       <= 1'b1;
		end else begin
			addr_hi_reg    <= ea_next[15:8];
			addr_hi_oe_reg <= nx_ext & hi_next;
			addr_lo_reg    <= ea_next[7:0];
			addr_lo_oe_reg <= nx_ext & ~mux_next;
			data_out_reg   <= nx_alen ? ea_next[7:0] : wd_next;
			data_oe_reg    <= (nx_ext & mux_next & nx_alen) | data_phase;
			ale_reg        <= nx_ale & last_off_next;
			rd_n_reg       <= ~(nx_strobe & ~wr_next);
			wr_n_reg       <= ~(nx_strobe & wr_next);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			done_reg  <= 1'b0;
			busy_reg  <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			done_reg <= (state_next == EMT_ST_DONE);
			busy_reg <= (state_next != EMT_ST_IDLE) & (state_next != EMT_ST_DONE);
			if (capture) rdata_reg <= data_in;
			if (state_reg == EMT_ST_INT && !wr_reg) rdata_reg <= ram_q;
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign req_busy    = busy_reg;
	assign req_done    = done_reg;
	assign req_rdata   = rdata_reg;
	assign addr_hi_out = addr_hi_reg;
	assign addr_hi_oe  = addr_hi_oe_reg;
	assign addr_lo_out = addr_lo_reg;
	assign addr_lo_oe  = addr_lo_oe_reg;
	assign data_out    = data_out_reg;
	assign data_oe     = data_oe_reg;
	assign ale         = ale_reg;
	assign rd_n        = rd_n_reg;
	assign wr_n        = wr_n_reg;

endmodule

// File: emt_ext_mem_properties.sv
// concurrent checks on the bus and strobe pins of the external memory block
`timescale 1ns/100ps
module emt_ext_mem_properties (
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic req_busy,
	input wire logic req_done,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic data_oe,
	input wire logic addr_lo_oe
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	sequence apb_setup;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence strobe_end;
		$rose(rd_n) || $rose(wr_n);
	endsequence
	sequence tail_then_done;
		!req_done ##1 !req_done ##[1:4] req_done;
	endsequence
	a_apb_one_wait: assert property (apb_setup |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_strobe_excl: assert property (rd_n || wr_n)
		else $error("both strobes low");
	a_strobe_in_busy: assert property (!rd_n || !wr_n |-> req_busy)
		else $error("strobe outside an access");
	a_hold_tail_done: assert property (strobe_end |-> tail_then_done)
		else $error("done not two to five cycles after strobe");
	a_latch_width: assert property ($rose(ale) |-> ##[1:4] !ale)
		else $error("latch pulse longer than four cycles");
	a_latch_no_strobe: assert property (ale |-> rd_n && wr_n)
		else $error("strobe during latch phase");
	a_nonmux_no_latch: assert property (addr_lo_oe |-> !ale)
		else $error("latch pulse in non-multiplexed access");
	a_done_pulse: assert property (req_done |=> !req_done && !req_busy)
		else $error("done longer than one cycle");
	a_busy_ends_done: assert property ($fell(req_busy) |-> req_done)
		else $error("busy fell without done");
	a_write_data_on: assert property (!wr_n |-> data_oe)
		else $error("write strobe with data bus released");
endmodule

bind emt_ext_mem emt_ext_mem_properties chk_u (.*);

// File: emt_xmem_model.sv
// external byte-wide memory with address latch, seen from the device pins
`timescale 1ns/100ps
module emt_xmem_model (
	input wire logic       clock,
	input wire logic [7:0] addr_hi_out,
	input wire logic       addr_hi_oe,
	input wire logic [7:0] addr_lo_out,
	input wire logic       addr_lo_oe,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       ale,
	input wire logic       rd_n,
	input wire logic       wr_n,
	output logic     [7:0] data_in
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lat  = 8'h00;
	logic [7:0]  last = 8'h00;
	// undriven high byte reads as a port latch held at zero
	wire  [15:0] addr = {addr_hi_oe ? addr_hi_out : 8'h00, addr_lo_oe ? addr_lo_out : lat};
	// released bus shows the inverse of the last byte, never a stale copy
	assign data_in = rd_n ? ~last : mem[addr];
	always @(posedge clock) begin
		if (ale && data_oe)
			lat <= data_out;
		if (!rd_n)
			last <= mem[addr];
		if (!wr_n)
			mem[addr] <= data_out;
	end
endmodule

// File: ext_memory_mode_and_timing_tb_top.sv
// self-checking bench for the external memory mode and timing block
`timescale 1ns/100ps
module ext_memory_mode_and_timing_tb_top;
	localparam logic [11:0] TC = 12'h2A8, CF = 12'h280, PG = 12'h284, NO = 12'h2FC;
	localparam logic [11:0] ST = 12'h288;
	logic        clock, rstn, psel, penable, pwrite, req, req_write, req_wide;
	logic        pready, pslverr, req_busy, req_done, addr_hi_oe, addr_lo_oe;
	logic        data_oe, ale, rd_n, wr_n, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] data_pointer;
	logic [7:0]  indirect_low, req_wdata, req_rdata, addr_hi_out, addr_lo_out;
	logic [7:0]  data_out, data_in, tc, cf;
	int          fails, cmp_count;
	emt_ext_mem dut_u (.*);
	emt_xmem_model mem_u (.*);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task hang;
		fails++;
		close_out;
	endtask
	task chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50)
			hang;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && a == TC)
			tc = d;
		if (w && a == CF)
			cf = d;
		// idle edge so psel is never assigned twice in one time step
		@(posedge clock);
	endtask
	// mux adds both latch phases; hold and setup come straight from the fields
	function automatic int dur;
		return 5 + tc[7:6] + tc[5:2] + tc[1:0] + (cf[4] ? 0 : 2 * (cf[1:0] + 1));
	endfunction
	task xfer(input logic w, wd, input logic [15:0] dp, input logic [7:0] dat, input int n,
		input logic off, oe, input logic [15:0] ea);
		int          i, s;
		logic [17:0] seen;
		@(posedge clock);
		req <= 1'b1;
		req_write <= w;
		req_wide <= wd;
		data_pointer <= dp;
		indirect_low <= dp[7:0];
		req_wdata <= dat;
		i = 0;
		s = 0;
		seen = '0;
		do begin
			@(posedge clock);
			i++;
			if (!rd_n || !wr_n) begin
				s++;
				seen = {addr_lo_oe, addr_hi_oe, addr_hi_out, addr_lo_oe ? addr_lo_out : mem_u.lat};
			end
		end while (req_done !== 1'b1 && i < 300);
		if (i >= 300)
			hang;
		req <= 1'b0;
		chk("duration", n, i - 1);
		if (!w)
			chk("read data", dat, req_rdata);
		if (off) begin
			chk("strobe width", tc[5:2] + 1, s);
			chk("high enable", oe, seen[16]);
			chk("low enable", cf[4], seen[17]);
			chk("address", {oe ? ea[15:8] : 8'h00, ea[7:0]},
				{oe ? seen[15:8] : 8'h00, seen[7:0]});
		end
	endtask
	initial begin
		repeat (50000) @(posedge clock);
		hang;
	end
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, req, req_write, req_wide} = '0;
		{paddr, pwdata, data_pointer, indirect_low, req_wdata} = '0;
		{fails, cmp_count} = '0;
		tc = 8'hFF;
		cf = 8'h00;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		apb(1'b0, TC, 8'h00);
		chk("timing reset", 32'hFF, q);
		apb(1'b0, CF, 8'h00);
		chk("config reset", 32'h0, q);
		apb(1'b0, NO, 8'h00);
		chk("unmapped error", 32'h1, err);
		xfer(1, 1, 16'h0010, 8'h5A, 2, 0, 0, 0);
		xfer(0, 1, 16'h2010, 8'h5A, 2, 0, 0, 0);
		apb(1'b1, CF, 8'h1C);
		xfer(1, 1, 16'h3456, 8'hA5, 26, 1, 1, 16'h3456);
		apb(1'b1, TC, 8'h00);
		xfer(1, 1, 16'h0012, 8'h3C, 5, 1, 1, 16'h0012);
		apb(1'b1, CF, 8'h14);
		apb(1'b1, PG, 8'h40);
		xfer(0, 0, 16'h0012, 8'h3C, 5, 1, 0, 16'h4012);
		xfer(1, 1, 16'h1000, 8'h77, 2, 0, 0, 0);
		xfer(0, 1, 16'h3456, 8'hA5, 5, 1, 1, 16'h3456);
		apb(1'b1, CF, 8'h18);
		apb(1'b1, PG, 8'h34);
		apb(1'b0, PG, 8'h00);
		chk("page readback", 32'h34, q);
		xfer(0, 0, 16'h0056, 8'hA5, 5, 1, 1, 16'h3456);
		apb(1'b1, PG, 8'h01);
		xfer(1, 0, 16'h0023, 8'h99, 2, 0, 0, 0);
		xfer(0, 1, 16'h0123, 8'h99, 2, 0, 0, 0);
		apb(1'b1, CF, 8'h1C);
		apb(1'b1, PG, 8'h34);
		xfer(0, 0, 16'h0012, 8'h3C, 5, 1, 0, 16'h3412);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, TC, {k[1:0], 4'(k * 5), k[1:0]});
			apb(1'b0, TC, 8'h00);
			chk("timing readback", {24'h0, tc}, q);
			apb(1'b1, CF, 8'h0C | 8'(k));
			xfer(0, 1, 16'h3456, 8'hA5, dur(), 1, 1, 16'h3456);
		end
		// idle after an off-chip access: last-offchip flag set, busy and state clear
		apb(1'b0, ST, 8'h00);
		chk("status", 32'h80, q);
		close_out;
	end
endmodule
